// ==== design/nrio_port.sv ====
`timescale 1ns/100ps
// Contract
// RULE1 - Remote words are 16 bits with eight axes, 8 bits with sixteen axes.
// RULE2 - Input slots default to operation bits, launch, home, stop, free, selects, runs.
// RULE3 - Output slots default to echo, origin, ready, warn, alarm, busy, zones, status.
// RULE4 - Any input function can be mapped onto each input slot.
// RULE5 - Master gives code, strobe at bit 6 and little-endian write data.
// RULE6 - A command executes only on a strobe rising edge.
// RULE7 - Response echoes the command code received.
// RULE8 - Completion flag at bit 6 rises when processing finishes.
// RULE9 - Status bit 7 is 0 for normal and 1 for error.
// RULE10 - Read-back data is returned least significant byte first.
// RULE11 - Forward and reverse run while 1, decelerate to stop at 0.
// RULE12 - Launch, sequence, homing and step inputs start operations at 1.
// RULE13 - Each direct select launches positioning with its configured entry number.
// RULE14 - Six operation bits select entry 0 to 63.
// RULE15 - Free at 1 de-energises windings and releases the brake.
// RULE16 - Excitation input energises at 1 and de-energises at 0.
// RULE17 - Alarm clear resets alarm; position load presets position at 1.
// RULE18 - Absolute-error clear at 1 resets the absolute position alarm.
// RULE19 - Tool unlock at 1 lifts the setting tool lockout.
// RULE20 - Sixteen general flags hold 1 for on, 0 for off.
// RULE21 - Function mapped to several slots acts when any slot is active.
// RULE22 - Unmapped excitation and tool unlock read as 1.
// RULE23 - Input on both terminal and slot acts only when both are 1.
// RULE24 - Positioning done is 1 after completion, 0 while moving.
// RULE25 - Master drops strobe after completion; device then clears its flag.
module nrio_port
  import nrio_pkg::*;
#(
  parameter int SLOTS = NRIO_SLOTS
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Configuration
  input  wire logic        narrow_mode_i,
  input  wire logic        map_we_i,
  input  wire logic [3:0]  map_slot_i,
  input  wire logic [4:0]  map_fn_i,
  input  wire logic [5:0]  dsel_entry_i [6],
  // Remote words
  input  wire logic [SLOTS-1:0] net_in_i,
  output logic      [SLOTS-1:0] net_out_o,
  // Physical terminals
  input  wire logic [NRIO_FN_COUNT-1:0] term_in_i,
  input  wire logic [NRIO_FN_COUNT-1:0] term_map_i,
  // Motion core
  input  wire nrio_stat_t  stat_i,
  output nrio_req_t        req_o,
  output logic             pos_go_o,
  output logic [5:0]       pos_entry_o,
  output logic             run_fwd_o,
  output logic             run_rev_o,
  output logic             energise_o,
  output logic             brake_release_o,
  output logic             tool_unlock_o,
  // Command channel
  input  wire nrio_cmd_t   cmd_i,
  output nrio_rsp_t        rsp_o,
  output logic             exec_o,
  output logic [NRIO_CODE_W-1:0] exec_code_o,
  output logic [NRIO_DATA_W-1:0] exec_data_o,
  input  wire logic        exec_done_i,
  input  wire logic        exec_err_i,
  input  wire logic [NRIO_DATA_W-1:0] exec_rdata_i
);

  nrio_map_t              map_q;
  logic [SLOTS-1:0]       in_s1_q;
  logic [SLOTS-1:0]       in_s2_q;
  logic [NRIO_FN_COUNT-1:0] term_s1_q;
  logic [NRIO_FN_COUNT-1:0] term_s2_q;
  logic [SLOTS-1:0]       in_eff;
  logic [NRIO_FN_COUNT-1:0] fn_act;
  logic [NRIO_FN_COUNT-1:0] fn_mapped;
  logic [NRIO_FN_COUNT-1:0] fn_val;
  logic [NRIO_FN_COUNT-1:0] fn_q;
  logic [5:0]             dsel_hit;
  logic [5:0]             dsel_entry;
  logic                   pos_rise;
  logic [SLOTS-1:0]       out_d;

  // Slot map
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      map_q <= NRIO_MAP_RESET; // RULE2
    end else if (map_we_i) begin
      map_q[map_slot_i] <= map_fn_i; // RULE4
    end
  end

  // Synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_s1_q   <= '0;
      in_s2_q   <= '0;
      term_s1_q <= '0;
      term_s2_q <= '0;
    end else begin
      in_s1_q   <= net_in_i;
      in_s2_q   <= in_s1_q;
      term_s1_q <= term_in_i;
      term_s2_q <= term_s1_q;
    end
  end

  // Upper slots unused in narrow mode
  assign in_eff = narrow_mode_i ? {{(SLOTS-NRIO_NARROW_W){1'b0}}, in_s2_q[NRIO_NARROW_W-1:0]} : in_s2_q; // RULE1

  always_comb begin
    fn_act    = '0;
    fn_mapped = '0;
    for (int s = 0; s < SLOTS; s++) begin
      if (!(narrow_mode_i && s >= NRIO_NARROW_W)) begin
        fn_mapped[map_q[s]] = 1'b1;
        fn_act[map_q[s]]    = fn_act[map_q[s]] | in_eff[s]; // RULE21
      end
    end
  end

  always_comb begin
    for (int f = 0; f < NRIO_FN_COUNT; f++) begin
      if (!fn_mapped[f] && (f == NRIO_FN_EXCITE || f == NRIO_FN_TOOL_UNLK)) begin
        fn_val[f] = term_map_i[f] ? term_s2_q[f] : 1'b1; // RULE22
      end else if (term_map_i[f] && fn_mapped[f]) begin
        fn_val[f] = term_s2_q[f] & fn_act[f]; // RULE23
      end else if (term_map_i[f]) begin
        fn_val[f] = term_s2_q[f];
      end else begin
        fn_val[f] = fn_act[f];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fn_q <= '0;
    end else begin
      fn_q <= fn_val;
    end
  end

  // Decoded requests
  always_comb begin
    req_o             = '0;
    req_o.op_num      = fn_q[NRIO_FN_OPNUM5:NRIO_FN_OPNUM0]; // RULE14
    req_o.launch      = fn_q[NRIO_FN_LAUNCH]; // RULE12
    req_o.home        = fn_q[NRIO_FN_HOME];
    req_o.stop        = fn_q[NRIO_FN_STOP];
    req_o.free_run    = fn_q[NRIO_FN_FREE];
    req_o.dsel        = fn_q[NRIO_FN_DSEL5:NRIO_FN_DSEL0];
    req_o.seq         = fn_q[NRIO_FN_SEQ];
    req_o.step_plus   = fn_q[NRIO_FN_STEP_PLUS];
    req_o.step_minus  = fn_q[NRIO_FN_STEP_MINUS];
    req_o.forward_run         = fn_q[NRIO_FN_FWD];
    req_o.rev         = fn_q[NRIO_FN_REV];
    req_o.excite      = fn_q[NRIO_FN_EXCITE];
    req_o.alm_clr     = fn_q[NRIO_FN_ALM_CLR]; // RULE17
    req_o.preset      = fn_q[NRIO_FN_PRESET];
    req_o.abs_clr     = fn_q[NRIO_FN_ABS_CLR]; // RULE18
    req_o.tool_unlock = fn_q[NRIO_FN_TOOL_UNLK];
    req_o.gflags      = {16{fn_q[NRIO_FN_GFLAGS]}} & in_eff; // RULE20 RULE1
  end

  // Direct select priority: lowest index wins
  always_comb begin
    dsel_hit   = fn_q[NRIO_FN_DSEL5:NRIO_FN_DSEL0];
    dsel_entry = fn_q[NRIO_FN_OPNUM5:NRIO_FN_OPNUM0];
    for (int i = 5; i >= 0; i--) begin
      if (dsel_hit[i]) begin
        dsel_entry = dsel_entry_i[i]; // RULE13
      end
    end
  end

  logic launch_prev_q;
  logic [5:0] dsel_prev_q;

  assign pos_rise = (fn_q[NRIO_FN_LAUNCH] & ~launch_prev_q) | (|(dsel_hit & ~dsel_prev_q));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      launch_prev_q <= 1'b0;
      dsel_prev_q   <= '0;
      pos_go_o      <= 1'b0;
      pos_entry_o   <= '0;
    end else begin
      launch_prev_q <= fn_q[NRIO_FN_LAUNCH];
      dsel_prev_q   <= dsel_hit;
      pos_go_o      <= pos_rise; // RULE12
      if (pos_rise) begin
        pos_entry_o <= dsel_entry;
      end
    end
  end

  // Drive commands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_fwd_o       <= 1'b0;
      run_rev_o       <= 1'b0;
      energise_o      <= 1'b0;
      brake_release_o <= 1'b0;
      tool_unlock_o   <= 1'b0;
    end else begin
      run_fwd_o       <= fn_q[NRIO_FN_FWD] & ~fn_q[NRIO_FN_REV]; // RULE11
      run_rev_o       <= fn_q[NRIO_FN_REV] & ~fn_q[NRIO_FN_FWD]; // RULE11
      energise_o      <= fn_q[NRIO_FN_EXCITE] & ~fn_q[NRIO_FN_FREE]; // RULE16
      brake_release_o <= fn_q[NRIO_FN_FREE]; // RULE15
      tool_unlock_o   <= fn_q[NRIO_FN_TOOL_UNLK]; // RULE19
    end
  end

  // Output word
  always_comb begin
    out_d                 = '0;
    out_d[2:0]            = fn_q[NRIO_FN_OPNUM2:NRIO_FN_OPNUM0]; // RULE3
    out_d[3]              = fn_q[NRIO_FN_LAUNCH];
    out_d[NRIO_O_ORIGIN]  = stat_i.origin;
    out_d[NRIO_O_READY]   = stat_i.ready;
    out_d[NRIO_O_WARN]    = stat_i.warn;
    out_d[NRIO_O_ALARM]   = stat_i.alarm;
    out_d[NRIO_O_BUSY]    = stat_i.busy;
    out_d[NRIO_O_ZONE1+:3] = stat_i.zone;
    out_d[NRIO_O_SHAFT]   = stat_i.shaft;
    out_d[NRIO_O_MOVING]  = stat_i.moving;
    out_d[NRIO_O_DONE]    = stat_i.done & ~stat_i.moving; // RULE24
    out_d[NRIO_O_TORQUE]  = stat_i.torque;
    if (narrow_mode_i) begin
      out_d[SLOTS-1:NRIO_NARROW_W] = '0; // RULE1
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      net_out_o <= '0;
    end else begin
      net_out_o <= out_d;
    end
  end

  // Command channel; payload layout is the master's duty
  nrio_cmd_channel u_cmd ( // RULE5
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .cmd_i        (cmd_i),
    .exec_o       (exec_o),
    .exec_code_o  (exec_code_o),
    .exec_data_o  (exec_data_o),
    .exec_done_i  (exec_done_i),
    .exec_err_i   (exec_err_i),
    .exec_rdata_i (exec_rdata_i),
    .rsp_o        (rsp_o)
  );

endmodule // nrio_port

// ==== design/nrio_pkg.sv ====
package nrio_pkg;

  // Input function codes
  typedef enum logic [4:0] {
    NRIO_FN_NONE       = 5'h00,
    NRIO_FN_OPNUM0     = 5'h01,
    NRIO_FN_OPNUM1     = 5'h02,
    NRIO_FN_OPNUM2     = 5'h03,
    NRIO_FN_OPNUM3     = 5'h04,
    NRIO_FN_OPNUM4     = 5'h05,
    NRIO_FN_OPNUM5     = 5'h06,
    NRIO_FN_LAUNCH     = 5'h07,
    NRIO_FN_HOME       = 5'h08,
    NRIO_FN_STOP       = 5'h09,
    NRIO_FN_FREE       = 5'h0A,
    NRIO_FN_DSEL0      = 5'h0B,
    NRIO_FN_DSEL1      = 5'h0C,
    NRIO_FN_DSEL2      = 5'h0D,
    NRIO_FN_DSEL3      = 5'h0E,
    NRIO_FN_DSEL4      = 5'h0F,
    NRIO_FN_DSEL5      = 5'h10,
    NRIO_FN_SEQ        = 5'h11,
    NRIO_FN_STEP_PLUS  = 5'h12,
    NRIO_FN_STEP_MINUS = 5'h13,
    NRIO_FN_FWD        = 5'h14,
    NRIO_FN_REV        = 5'h15,
    NRIO_FN_EXCITE     = 5'h16,
    NRIO_FN_ALM_CLR    = 5'h17,
    NRIO_FN_PRESET     = 5'h18,
    NRIO_FN_ABS_CLR    = 5'h19,
    NRIO_FN_TOOL_UNLK  = 5'h1A,
    NRIO_FN_GFLAGS     = 5'h1B
  } nrio_fn_t;

  localparam int NRIO_SLOTS     = 16;
  localparam int NRIO_FN_COUNT  = 32;
  localparam int NRIO_NARROW_W  = 8;
  localparam int NRIO_STROBE_BIT = 6;
  localparam int NRIO_STATUS_BIT = 7;
  localparam int NRIO_CODE_W    = 14;
  localparam int NRIO_DATA_W    = 32;

  // Output slot positions
  localparam int NRIO_O_ORIGIN  = 4;
  localparam int NRIO_O_READY   = 5;
  localparam int NRIO_O_WARN    = 6;
  localparam int NRIO_O_ALARM   = 7;
  localparam int NRIO_O_BUSY    = 8;
  localparam int NRIO_O_ZONE1   = 9;
  localparam int NRIO_O_SHAFT   = 12;
  localparam int NRIO_O_MOVING  = 13;
  localparam int NRIO_O_DONE    = 14;
  localparam int NRIO_O_TORQUE  = 15;

  typedef logic [4:0] nrio_fn_code_t;
  typedef nrio_fn_code_t [NRIO_SLOTS-1:0] nrio_map_t;

  localparam nrio_map_t NRIO_MAP_RESET = {
    NRIO_FN_REV, NRIO_FN_FWD, NRIO_FN_STEP_MINUS, NRIO_FN_STEP_PLUS,
    NRIO_FN_SEQ, NRIO_FN_DSEL2, NRIO_FN_DSEL1, NRIO_FN_DSEL0,
    NRIO_FN_NONE, NRIO_FN_FREE, NRIO_FN_STOP, NRIO_FN_HOME,
    NRIO_FN_LAUNCH, NRIO_FN_OPNUM2, NRIO_FN_OPNUM1, NRIO_FN_OPNUM0};

  // Command word from the master
  typedef struct packed {
    logic                   strobe;
    logic [NRIO_CODE_W-1:0] code;
    logic [NRIO_DATA_W-1:0] data;
  } nrio_cmd_t;

  // Response word to the master
  typedef struct packed {
    logic                   status;
    logic                   done;
    logic [NRIO_CODE_W-1:0] code;
    logic [NRIO_DATA_W-1:0] data;
  } nrio_rsp_t;

  // Status from the motion core
  typedef struct packed {
    logic       origin;
    logic       ready;
    logic       warn;
    logic       alarm;
    logic       busy;
    logic [2:0] zone;
    logic       shaft;
    logic       moving;
    logic       done;
    logic       torque;
  } nrio_stat_t;

  // Decoded operation requests
  typedef struct packed {
    logic [5:0]  op_num;
    logic        launch;
    logic        home;
    logic        stop;
    logic        free_run;
    logic [5:0]  dsel;
    logic        seq;
    logic        step_plus;
    logic        step_minus;
    logic        forward_run;
    logic        rev;
    logic        excite;
    logic        alm_clr;
    logic        preset;
    logic        abs_clr;
    logic        tool_unlock;
    logic [15:0] gflags;
  } nrio_req_t;

endpackage

// ==== design/nrio_cmd_channel.sv ====
`timescale 1ns/100ps
module nrio_cmd_channel
  import nrio_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Master command
  input  wire nrio_cmd_t  cmd_i,
  // Executor
  output logic            exec_o,
  output logic [NRIO_CODE_W-1:0] exec_code_o,
  output logic [NRIO_DATA_W-1:0] exec_data_o,
  input  wire logic       exec_done_i,
  input  wire logic       exec_err_i,
  input  wire logic [NRIO_DATA_W-1:0] exec_rdata_i,
  // Response
  output nrio_rsp_t       rsp_o
);

  typedef enum logic [1:0] {NRIO_IDLE, NRIO_RUN, NRIO_HOLD} nrio_st_t;

  nrio_st_t st_q;
  logic     strobe_q;
  logic     rise;

  assign rise = cmd_i.strobe & ~strobe_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= cmd_i.strobe;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q        <= NRIO_IDLE;
      exec_code_o <= '0;
      exec_data_o <= '0;
      rsp_o       <= '0;
    end else begin
      case (st_q)
        NRIO_IDLE: begin
          if (rise) begin // RULE6
            exec_code_o <= cmd_i.code;
            exec_data_o <= cmd_i.data;
            st_q        <= NRIO_RUN;
          end
        end
        NRIO_RUN: begin
          if (exec_done_i) begin
            rsp_o.code   <= exec_code_o; // RULE7
            rsp_o.status <= exec_err_i; // RULE9
            rsp_o.data   <= exec_rdata_i; // RULE10
            rsp_o.done   <= 1'b1; // RULE8
            st_q         <= NRIO_HOLD;
          end
        end
        NRIO_HOLD: begin
          if (!cmd_i.strobe) begin
            rsp_o.done <= 1'b0; // RULE25
            st_q       <= NRIO_IDLE;
          end
        end
        default: st_q <= NRIO_IDLE;
      endcase
    end
  end

  assign exec_o = (st_q == NRIO_RUN);

endmodule // nrio_cmd_channel

// ==== tb/nrio_port_checker.sv ====
`timescale 1ns/100ps
module nrio_port_checker
  import nrio_pkg::*;
#(
  parameter int SLOTS = NRIO_SLOTS
) (
  // Clock and reset
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  // Remote words and motion
  input wire logic                   narrow_mode_i,
  input wire nrio_stat_t             stat_i,
  input wire logic [SLOTS-1:0]       net_out_o,
  input wire logic                   pos_go_o,
  input wire logic                   run_fwd_o,
  input wire logic                   run_rev_o,
  input wire logic                   energise_o,
  input wire logic                   brake_release_o,
  // Command channel
  input wire nrio_cmd_t              cmd_i,
  input wire nrio_rsp_t              rsp_o,
  input wire logic                   exec_o,
  input wire logic [NRIO_CODE_W-1:0] exec_code_o,
  input wire logic [NRIO_DATA_W-1:0] exec_data_o,
  input wire logic                   exec_done_i,
  input wire logic                   exec_err_i,
  input wire logic [NRIO_DATA_W-1:0] exec_rdata_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_exec_on_rise: assert property ($rose(cmd_i.strobe) && !exec_o && !rsp_o.done |=> exec_o &&
    exec_code_o == $past(cmd_i.code) && exec_data_o == $past(cmd_i.data)) else $error("command not launched");
  a_exec_cause: assert property ($rose(exec_o) |-> $past(cmd_i.strobe) && !$past(cmd_i.strobe, 2))
    else $error("launch without strobe rise");
  a_done_result: assert property (exec_o && exec_done_i |=> rsp_o.done && rsp_o.status == $past(exec_err_i) &&
    rsp_o.data == $past(exec_rdata_i)) else $error("response not posted");
  a_code_echo: assert property ($rose(rsp_o.done) |-> rsp_o.code == exec_code_o)
    else $error("response code differs");
  a_done_hold: assert property (rsp_o.done && cmd_i.strobe |=> rsp_o.done)
    else $error("completion dropped early");
  a_done_clear: assert property (rsp_o.done && !cmd_i.strobe |=> !rsp_o.done && !exec_o)
    else $error("completion not cleared");
  a_narrow_zero: assert property (narrow_mode_i [*2] |-> net_out_o[15:8] == 8'h00)
    else $error("upper slots driven in narrow mode");
  a_status_low: assert property (!$past(rst_i) |-> net_out_o[7:4] == {$past(stat_i.alarm), $past(stat_i.warn),
    $past(stat_i.ready), $past(stat_i.origin)}) else $error("low status slots wrong");
  a_status_high: assert property (!$past(rst_i) && !$past(narrow_mode_i) |-> net_out_o[15:13] ==
    {$past(stat_i.torque), $past(stat_i.done) && !$past(stat_i.moving), $past(stat_i.moving)})
    else $error("high status slots wrong");
  a_run_excl: assert property (!(run_fwd_o && run_rev_o))
    else $error("both directions running");
  a_free_deen: assert property (brake_release_o |-> !energise_o)
    else $error("energised while free");
  a_go_pulse: assert property (pos_go_o |=> !pos_go_o)
    else $error("launch pulse too long");

  c_error_rsp: cover property ($rose(rsp_o.done) && rsp_o.status);
  c_launch: cover property ($rose(pos_go_o));
  c_run: cover property (run_fwd_o);
endmodule // nrio_port_checker

bind nrio_port nrio_port_checker #(.SLOTS(SLOTS)) chk (.clk_i(clk_i), .rst_i(rst_i), .narrow_mode_i(narrow_mode_i),
  .stat_i(stat_i), .net_out_o(net_out_o), .pos_go_o(pos_go_o), .run_fwd_o(run_fwd_o), .run_rev_o(run_rev_o),
  .energise_o(energise_o), .brake_release_o(brake_release_o), .cmd_i(cmd_i), .rsp_o(rsp_o), .exec_o(exec_o),
  .exec_code_o(exec_code_o), .exec_data_o(exec_data_o), .exec_done_i(exec_done_i), .exec_err_i(exec_err_i),
  .exec_rdata_i(exec_rdata_i));

// ==== tb/nrio_master_model.sv ====
`timescale 1ns/100ps
module nrio_master_model
  import nrio_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  // Command channel
  output nrio_cmd_t      cmd_o,
  input  wire nrio_rsp_t rsp_i
);
  int hold_cycles = 0;
  initial cmd_o = '0;

  // Raise strobe, wait for completion, drop strobe, wait for clear
  task automatic issue(input logic [NRIO_CODE_W-1:0] code, input logic [NRIO_DATA_W-1:0] data,
                       output nrio_rsp_t rsp, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge clk_i);
    cmd_o <= '{strobe: 1'b1, code: code, data: data};
    for (n = 0; n < 200 && !ok; n++) begin
      @(posedge clk_i);
      ok = (rsp_i.done === 1'b1);
    end
    rsp = rsp_i;
    repeat (hold_cycles) @(posedge clk_i);
    cmd_o <= '{strobe: 1'b0, code: ~code, data: ~data};
    for (n = 0; n < 200 && rsp_i.done !== 1'b0; n++) @(posedge clk_i);
    ok = ok && (rsp_i.done === 1'b0);
  endtask
endmodule // nrio_master_model

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import nrio_pkg::*;
  typedef struct packed {
    logic        n;
    logic [15:0] in;
    logic [11:0] st;
    logic [15:0] out;
    logic [3:0]  run;
  } nrio_row_t;
  logic        clk_i = 1'b0, rst_i = 1'b1, narrow_mode_i = 1'b0, map_we_i = 1'b0, exec_done_i = 1'b0;
  logic        exec_err_i = 1'b0, pos_go_o, run_fwd_o, run_rev_o, energise_o, brake_release_o, tool_unlock_o, exec_o;
  logic [3:0]  map_slot_i = '0;
  logic [4:0]  map_fn_i = '0;
  logic [5:0]  dsel_entry_i [6] = '{default: 6'h00};
  logic [5:0]  pos_entry_o;
  logic [15:0] net_in_i = '0, net_out_o;
  logic [31:0] term_in_i = '0, term_map_i = '0, exec_data_o, exec_rdata_i = '0;
  logic [13:0] exec_code_o;
  nrio_stat_t  stat_i = '0;
  nrio_req_t   req_o;
  nrio_cmd_t   cmd_i;
  nrio_rsp_t   rsp_o;
  int          bad_count = 0, comparisons = 0, ex_cnt = 0, ex_lat = 0;
  nrio_row_t   rows [9] = '{{1'b0, 16'h0000, 12'h600, 16'h0060, 4'h2}, {1'b0, 16'h4000, 12'h800, 16'h0010, 4'hA},
    {1'b0, 16'h8000, 12'h001, 16'h8000, 4'h6}, {1'b0, 16'hC000, 12'h006, 16'h2000, 4'h2},
    {1'b0, 16'h0040, 12'h002, 16'h4000, 4'h1}, {1'b0, 16'h0005, 12'h010, 16'h0205, 4'h2},
    {1'b0, 16'h000F, 12'h080, 16'h010F, 4'h2}, {1'b1, 16'h4000, 12'h001, 16'h0000, 4'h2},
    {1'b1, 16'h0003, 12'h100, 16'h0083, 4'h2}};

  always #50 clk_i = ~clk_i;

  nrio_port uut (.clk_i(clk_i), .rst_i(rst_i), .narrow_mode_i(narrow_mode_i), .map_we_i(map_we_i),
    .map_slot_i(map_slot_i), .map_fn_i(map_fn_i), .dsel_entry_i(dsel_entry_i), .net_in_i(net_in_i),
    .net_out_o(net_out_o), .term_in_i(term_in_i), .term_map_i(term_map_i), .stat_i(stat_i), .req_o(req_o),
    .pos_go_o(pos_go_o), .pos_entry_o(pos_entry_o), .run_fwd_o(run_fwd_o), .run_rev_o(run_rev_o),
    .energise_o(energise_o), .brake_release_o(brake_release_o), .tool_unlock_o(tool_unlock_o), .cmd_i(cmd_i),
    .rsp_o(rsp_o), .exec_o(exec_o), .exec_code_o(exec_code_o), .exec_data_o(exec_data_o),
    .exec_done_i(exec_done_i), .exec_err_i(exec_err_i), .exec_rdata_i(exec_rdata_i));

  nrio_master_model mst (.clk_i(clk_i), .rst_i(rst_i), .cmd_o(cmd_i), .rsp_i(rsp_o));

  // Executor answers ex_lat+1 cycles after exec_o rises
  always @(posedge clk_i) begin
    if (exec_o === 1'b1 && exec_done_i === 1'b0) begin
      ex_cnt <= ex_cnt + 1;
      if (ex_cnt >= ex_lat) begin
        exec_done_i <= 1'b1;
        ex_cnt      <= 0;
      end
    end else begin
      exec_done_i <= 1'b0;
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("mismatches=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic put_raw(input logic [15:0] v);
    @(posedge clk_i);
    net_in_i <= v;
  endtask

  task automatic put(input logic [15:0] v);
    put_raw(v);
    repeat (6) @(posedge clk_i);
  endtask

  task automatic map_set(input logic [3:0] slot, input logic [4:0] fn);
    @(posedge clk_i);
    map_we_i   <= 1'b1;
    map_slot_i <= slot;
    map_fn_i   <= fn;
    @(posedge clk_i);
    map_we_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic wait_go(input logic [5:0] exp);
    int n;
    @(negedge clk_i);
    for (n = 0; n < 20 && pos_go_o !== 1'b1; n++) @(negedge clk_i);
    if (pos_go_o !== 1'b1) begin
      bad_count++;
      test_done();
    end
    check(pos_entry_o, exp);
  endtask

  task automatic run_cmd(input logic [13:0] code, input logic [31:0] data, input logic err, input logic [31:0] rd,
                         input int lat, input int hold);
    nrio_rsp_t r;
    bit        ok;
    @(posedge clk_i);
    exec_err_i   <= err;
    exec_rdata_i <= rd;
    ex_lat       <= lat;
    mst.hold_cycles = hold;
    mst.issue(code, data, r, ok);
    if (!ok) begin
      bad_count++;
      test_done();
    end
    check(r, {err, 1'b1, code, rd});
    check({exec_code_o, exec_data_o}, {code, data});
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    check({net_out_o, pos_go_o, exec_o, rsp_o.done, run_fwd_o, energise_o}, '0);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clk_i);
      narrow_mode_i <= rows[i].n;
      stat_i        <= rows[i].st;
      put(rows[i].in);
      check(net_out_o, rows[i].out);
      check({run_fwd_o, run_rev_o, energise_o, brake_release_o}, rows[i].run);
    end
    @(posedge clk_i);
    narrow_mode_i <= 1'b0;
    put(16'h3830);
    check({req_o.home, req_o.seq, req_o.step_plus, req_o.step_minus, req_o.stop}, 5'b11111);
    put(16'h0000);
    map_set(4'h8, NRIO_FN_OPNUM5);
    put(16'h0101);
    put_raw(16'h0109);
    wait_go(6'h21);
    put(16'h0000);
    @(posedge clk_i);
    dsel_entry_i[1] <= 6'h2A;
    put_raw(16'h0200);
    wait_go(6'h2A);
    map_set(4'h7, NRIO_FN_FWD);
    put(16'h0080);
    check(run_fwd_o, 1'b1);
    term_map_i[NRIO_FN_FWD] <= 1'b1;
    put(16'h0080);
    check(run_fwd_o, 1'b0);
    term_in_i[NRIO_FN_FWD] <= 1'b1;
    put(16'h0080);
    check(run_fwd_o, 1'b1);
    for (int i = 0; i < 3; i++) begin
      map_set(4'h7, 5'h17 + 5'(i));
      check({req_o.alm_clr, req_o.preset, req_o.abs_clr}, 3'b100 >> i);
    end
    map_set(4'h7, NRIO_FN_TOOL_UNLK);
    check(tool_unlock_o, 1'b1);
    put(16'h0000);
    check(tool_unlock_o, 1'b0);
    map_set(4'h7, NRIO_FN_EXCITE);
    check({energise_o, tool_unlock_o}, 2'b01);
    map_set(4'h7, NRIO_FN_GFLAGS);
    put(16'h00A5);
    check(req_o.gflags, 16'h00A5);
    put(16'h0000);
    run_cmd(14'h0123, 32'h11223344, 1'b0, 32'hA1B2C3D4, 0, 0);
    run_cmd(14'h1018, 32'h000000FF, 1'b1, 32'h5A5A0001, 5, 3);
    repeat (4) @(posedge clk_i);
    check(exec_o, 1'b0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check({net_out_o, pos_go_o, exec_o, rsp_o.done, run_fwd_o, energise_o}, '0);
    rst_i <= 1'b0;
    put(16'h0100);
    check({req_o.op_num, req_o.dsel, energise_o}, {6'h00, 6'h01, 1'b1});
    test_done();
  end
endmodule // tb_top
